// >>> csc_combiner.sv
// terminal and serial command combiner with wishbone register access
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module csc_combiner (
    input  wire logic                        clock,         // 125 mhz
    input  wire logic                        rst,           // async, high
    input  wire logic [7:0]                  wb_adr_i,      // byte address
    input  wire logic [31:0]                 wb_dat_i,      // write data
    output logic      [31:0]                 wb_dat_o,      // read data
    input  wire logic [3:0]                  wb_sel_i,      // byte enables
    input  wire logic                        wb_we_i,       // write
    input  wire logic                        wb_cyc_i,      // cycle
    input  wire logic                        wb_stb_i,      // strobe
    output logic                             wb_ack_o,      // acknowledge
    input  wire logic [15:0]                 ctrl_word,     // serial word
    input  wire logic                        ctrl_word_vld, // word accepted
    input  wire logic                        term_coast_n,  // pin, low=coast
    input  wire logic                        term_qstop_n,  // pin, low=qstop
    input  wire logic                        term_dcbrk_n,  // pin, low=brake
    input  wire logic                        term_start,    // pin, high=start
    input  wire logic                        term_rev,      // pin, high=ccw
    input  wire logic                        panel_rate_we, // panel write
    input  wire logic [csc_pkg::CSC_RATE_WIDTH-1:0] panel_rate, // panel code
    output logic [csc_pkg::CSC_RATE_WIDTH-1:0] link_rate,   // speed code
    output logic                             run_coast,     // 1=no coast
    output logic                             run_qstop,     // 1=no qstop
    output logic                             run_dcbrk,     // 1=no brake
    output logic                             start_cmd,     // 1=start
    output logic                             rev_ccw        // 1=ccw
);
    import csc_pkg::*;

    // merge two active-high requests according to a selector
    function automatic logic merge(input logic [1:0] sel,
                                   input logic t, input logic s);
        logic r;
        r = 1'b0;
        case (csc_src_e'(sel))
            CSC_SRC_TERM: r = t;
            CSC_SRC_SER:  r = s;
            CSC_SRC_AND:  r = t & s;
            CSC_SRC_OR:   r = t | s;
            default:      r = 1'b0;
        endcase
        return r;
    endfunction : merge

    // run permit for an active-low stop: merge the stop requests
    function automatic logic run_low(input logic [1:0] sel,
                                     input logic t_n, input logic s_n);
        return ~merge(sel, ~t_n, ~s_n);
    endfunction : run_low

    // terminal synchronisers, reset to idle levels so no false start
    logic [4:0] pin_meta;
    logic [4:0] pin_sync;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_meta <= CSC_PIN_RST;
            pin_sync <= CSC_PIN_RST;
        end else begin
            pin_meta <= {term_rev, term_start, term_dcbrk_n,
                         term_qstop_n, term_coast_n};
            pin_sync <= pin_meta;
        end
    end
    logic t_coast_n, t_qstop_n, t_dcbrk_n, t_start, t_rev;
    assign t_coast_n = pin_sync[0];
    assign t_qstop_n = pin_sync[1];
    assign t_dcbrk_n = pin_sync[2];
    assign t_start   = pin_sync[3];
    assign t_rev     = pin_sync[4];

    // configuration and latched control word
    logic [CSC_SEL_WIDTH-1:0]  sel, next_sel;
    logic [CSC_RATE_WIDTH-1:0] next_link_rate;
    logic [15:0]               cw, next_cw;
    logic                      bus_req, bus_wr;
    logic [31:0]               next_dat;
    logic [31:0]               wmask;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr  = bus_req & wb_we_i;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    logic [1:0] s_coast, s_qstop, s_dcbrk, s_start, s_rev;
    assign s_coast = sel[CSC_SEL_COAST +: 2];             // [R3]
    assign s_qstop = sel[CSC_SEL_QSTOP +: 2];
    assign s_dcbrk = sel[CSC_SEL_DCBRK +: 2];
    assign s_start = sel[CSC_SEL_START +: 2];
    assign s_rev   = sel[CSC_SEL_REV   +: 2];

    always_comb begin
        next_sel       = sel;
        next_link_rate = link_rate;
        next_cw        = cw;
        if (bus_wr && wb_adr_i == CSC_ADDR_SEL) begin
            next_sel = (sel & ~wmask[CSC_SEL_WIDTH-1:0])
                     | (wb_dat_i[CSC_SEL_WIDTH-1:0]
                        & wmask[CSC_SEL_WIDTH-1:0]);      // [R3]
        end
        // bus and serial link have no path to the speed code
        if (panel_rate_we) begin
            next_link_rate = panel_rate;                  // [R2]
        end
        if (ctrl_word_vld) begin
            next_cw = ctrl_word;                          // [R15]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel       <= CSC_SEL_RST;                     // [R4]
            link_rate <= CSC_RATE_RST;
            cw        <= CSC_CW_RST;
        end else begin
            sel       <= next_sel;
            link_rate <= next_link_rate;
            cw        <= next_cw;
        end
    end

    // combined commands, registered every cycle
    logic next_run_coast, next_run_qstop, next_run_dcbrk;
    logic next_start_cmd, next_rev_ccw;
    always_comb begin
        next_run_coast = run_low(s_coast, t_coast_n,
                                 cw[CSC_CW_COAST]);       // [R7] [R8] [R5]
        next_run_qstop = run_low(s_qstop, t_qstop_n,
                                 cw[CSC_CW_QSTOP]);       // [R9] [R10]
        next_run_dcbrk = run_low(s_dcbrk, t_dcbrk_n,
                                 cw[CSC_CW_DCBRK]);       // [R11] [R12]
        next_start_cmd = merge(s_start, t_start,
                               cw[CSC_CW_START]);         // [R13] [R6]
        next_rev_ccw   = merge(s_rev, t_rev, cw[CSC_CW_REV]); // [R14]
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            run_coast <= 1'b0;
            run_qstop <= 1'b0;
            run_dcbrk <= 1'b0;
            start_cmd <= 1'b0;
            rev_ccw   <= 1'b0;
        end else begin                                    // [R15]
            run_coast <= next_run_coast;
            run_qstop <= next_run_qstop;
            run_dcbrk <= next_run_dcbrk;
            start_cmd <= next_start_cmd;
            rev_ccw   <= next_rev_ccw;
        end
    end

    // wishbone read mux, unmapped reads as zero
    always_comb begin
        next_dat = 32'h0000_0000;
        if (wb_adr_i == CSC_ADDR_SEL) begin
            next_dat[CSC_SEL_WIDTH-1:0] = sel;
        end else if (wb_adr_i == CSC_ADDR_RATE) begin
            next_dat[CSC_RATE_WIDTH-1:0] = link_rate;
        end else if (wb_adr_i == CSC_ADDR_STATUS) begin
            next_dat[9:0] = {t_rev, t_start, t_dcbrk_n, t_qstop_n,
                             t_coast_n, rev_ccw, start_cmd,
                             run_dcbrk, run_qstop, run_coast};
        end else if (wb_adr_i == CSC_ADDR_CWORD) begin
            next_dat[15:0] = cw;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_dat : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sel_reset_val_a: assert property ($fell(rst) |-> sel == CSC_SEL_RST) // [R4]
        else $error("selectors not at logic or after reset");
    sel_bus_only_a: assert property ($changed(sel) |->
        $past(bus_wr) && $past(wb_adr_i) == CSC_ADDR_SEL) // [R3]
        else $error("selector changed without a bus write");
    rate_panel_only_a: assert property ($changed(link_rate) |->
        $past(panel_rate_we)) // [R2]
        else $error("link speed changed without panel write");
    coast_serial_a: assert property (s_coast == 2'h1 ##1 $stable(s_coast)
        |-> run_coast == $past(cw[CSC_CW_COAST])) // [R5]
        else $error("serial mode coast not from serial bit");
    coast_or_run_a: assert property (s_coast == 2'h3 |=>
        run_coast == ($past(t_coast_n) & $past(cw[CSC_CW_COAST]))) // [R8]
        else $error("or mode coast wrong");
    qstop_and_run_a: assert property (s_qstop == 2'h2 |=>
        run_qstop == ($past(t_qstop_n) | $past(cw[CSC_CW_QSTOP]))) // [R10]
        else $error("and mode quick stop wrong");
    dcbrk_term_a: assert property (s_dcbrk == 2'h0 |=>
        run_dcbrk == $past(t_dcbrk_n)) // [R12]
        else $error("terminal mode dc brake wrong");
    start_and_a: assert property (s_start == 2'h2 |=>
        start_cmd == ($past(t_start) & $past(cw[CSC_CW_START]))) // [R6]
        else $error("and mode start wrong");
    rev_or_a: assert property (s_rev == 2'h3 |=>
        rev_ccw == ($past(t_rev) | $past(cw[CSC_CW_REV]))) // [R14]
        else $error("or mode reverse wrong");
    cw_latch_a: assert property (ctrl_word_vld |=>
        cw == $past(ctrl_word) ##1 1'b1) // [R15]
        else $error("control word not latched");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    qstop_serial_a: assert property (s_qstop == 2'h1 |=>
        run_qstop == $past(cw[CSC_CW_QSTOP])) // [R5]
        else $error("serial mode quick stop not from serial bit");
    start_term_a: assert property (s_start == 2'h0 |=>
        start_cmd == $past(t_start)) // [R13]
        else $error("terminal mode start wrong");

    start_seen_c: cover property (s_start == 2'h1 ##1 start_cmd);
    coast_seen_c: cover property (run_coast ##1 !run_coast);
    sel_write_c:  cover property (bus_wr && wb_adr_i == CSC_ADDR_SEL);
    rev_and_c:    cover property (s_rev == 2'h2 ##1 rev_ccw);
endmodule : csc_combiner

// >>> csc_pkg.sv
// package with register map, selector codes and control word layout
// Operation
// R1 - integrator matches link speed to master
// R2 - link speed settable only from panel
// R3 - each function has two-bit source selector
// R4 - selectors reset to logic OR
// R5 - serial mode uses serial bit only
// R6 - AND mode needs both sources
// R7 - coast terminal and bit 03 active low
// R8 - coast run truth table per mode
// R9 - quick stop terminal and bit 04 low
// R10 - quick stop run truth table per mode
// R11 - dc brake terminal and bit 02 low
// R12 - dc brake run truth table per mode
// R13 - start truth table per mode
// R14 - reverse truth table per mode
// R15 - outputs recomputed each cycle from latched inputs
package csc_pkg;
    typedef enum logic [1:0] {
        CSC_SRC_TERM,
        CSC_SRC_SER,
        CSC_SRC_AND,
        CSC_SRC_OR
    } csc_src_e;

    typedef logic [31:0] csc_word_t;

    // register byte addresses
    localparam logic [7:0]  CSC_ADDR_SEL    = 8'h00;
    localparam logic [7:0]  CSC_ADDR_RATE   = 8'h04;
    localparam logic [7:0]  CSC_ADDR_STATUS = 8'h08;
    localparam logic [7:0]  CSC_ADDR_CWORD  = 8'h0c;

    // selector field positions inside the selector register
    localparam int          CSC_SEL_COAST   = 0;
    localparam int          CSC_SEL_QSTOP   = 2;
    localparam int          CSC_SEL_DCBRK   = 4;
    localparam int          CSC_SEL_START   = 6;
    localparam int          CSC_SEL_REV     = 8;
    localparam int          CSC_SEL_WIDTH   = 10;
    localparam logic [9:0]  CSC_SEL_RST     = 10'h3ff;

    // link speed code, 9600 baud by default
    localparam int          CSC_RATE_WIDTH  = 3;
    localparam logic [2:0]  CSC_RATE_RST    = 3'h5;

    // control word bit positions
    localparam int          CSC_CW_DCBRK    = 2;
    localparam int          CSC_CW_COAST    = 3;
    localparam int          CSC_CW_QSTOP    = 4;
    localparam int          CSC_CW_START    = 6;
    localparam int          CSC_CW_REV      = 15;
    localparam logic [15:0] CSC_CW_RST      = 16'h0000;

    // idle pin levels: stop inputs high, start and reverse low
    localparam logic [4:0]  CSC_PIN_RST     = 5'h07;
endpackage : csc_pkg

// >>> csc_link_model.sv
// serial link master model feeding control words to the combiner
`timescale 1ns/1ps
module csc_link_model (
    input  wire logic        clock,         // 125 mhz
    input  wire logic        rst,           // async, high
    input  wire logic        send,          // request one word
    input  wire logic [15:0] word,          // word to send
    output logic      [15:0] ctrl_word,     // word to the drive
    output logic             ctrl_word_vld  // one-cycle strobe
);
    logic [15:0] last;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_word_vld <= 1'b0;
            ctrl_word     <= 16'h0000;
            last          <= 16'h0000;
        end else begin
            ctrl_word_vld <= send;
            last          <= send ? word : last;
            // outside the strobe the word is not held
            ctrl_word     <= send ? word : ~last;
        end
    end
endmodule : csc_link_model

// >>> command_source_combiner_tb.sv
// self-checking bench for the command source combiner
`timescale 1ns/1ps
module command_source_combiner_tb;
    import csc_pkg::*;
    logic clock = 0, rst = 1, we = 0, cyc = 0, send = 0, prw = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 0, dr, q;
    logic [3:0] sl = 4'h0;
    logic [15:0] wd = 0, cw;
    logic [4:0] tm = 5'h07;
    logic [2:0] pr = 3'h0, lr;
    logic ack, vld, r_co, r_qs, r_dc, st, rv;
    int n_mismatch = 0, checked = 0, cyc_cnt = 0;
    always #4 clock = ~clock;
    csc_link_model link_u (.clock(clock), .rst(rst), .send(send),
        .word(wd), .ctrl_word(cw), .ctrl_word_vld(vld));
    csc_combiner dut_u (.clock(clock), .rst(rst), .wb_adr_i(adr),
        .wb_dat_i(dw), .wb_dat_o(dr), .wb_sel_i(sl), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack), .ctrl_word(cw),
        .ctrl_word_vld(vld), .term_coast_n(tm[0]), .term_qstop_n(tm[1]),
        .term_dcbrk_n(tm[2]), .term_start(tm[3]), .term_rev(tm[4]),
        .panel_rate_we(prw), .panel_rate(pr), .link_rate(lr),
        .run_coast(r_co), .run_qstop(r_qs), .run_dcbrk(r_dc),
        .start_cmd(st), .rev_ccw(rv));
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                      logic [3:0] s);
        cyc <= 1'b1; we <= w; adr <= a; dw <= d; sl <= s;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        q = dr;
        cyc <= 1'b0; we <= 1'b0;
        @(posedge clock);
    endtask : wb
    function automatic logic f(logic [1:0] m, logic t, logic s, logic i);
        logic a, b, r;
        a = t ^ i;
        b = s ^ i;
        case (m)
            2'h0: r = a;
            2'h1: r = b;
            2'h2: r = a & b;
            default: r = a | b;
        endcase
        return r ^ i;
    endfunction : f
    task automatic apply(logic [9:0] s, logic [4:0] t, logic [15:0] w);
        logic [4:0] e;
        wb(1'b1, CSC_ADDR_SEL, {22'h0, s}, 4'hf);
        tm <= t; send <= 1'b1; wd <= w;
        @(posedge clock);
        send <= 1'b0;
        repeat (4) @(posedge clock);
        e[0] = f(s[1:0], t[0], w[3], 1'b1);
        e[1] = f(s[3:2], t[1], w[4], 1'b1);
        e[2] = f(s[5:4], t[2], w[2], 1'b1);
        e[3] = f(s[7:6], t[3], w[6], 1'b0);
        e[4] = f(s[9:8], t[4], w[15], 1'b0);
        chk("run_coast", r_co, e[0]);
        chk("run_qstop", r_qs, e[1]);
        chk("run_dcbrk", r_dc, e[2]);
        chk("start_cmd", st, e[3]);
        chk("rev_ccw", rv, e[4]);
        wb(1'b0, CSC_ADDR_STATUS, 0, 4'hf);
        chk("status", q, {22'h0, t, e});
        wb(1'b0, CSC_ADDR_CWORD, 0, 4'hf);
        chk("cword", q, {16'h0, w});
    endtask : apply
    always @(posedge clock) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(11));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wb(1'b0, CSC_ADDR_SEL, 0, 4'hf);
        chk("sel reset", q, 32'h0000_03ff);
        wb(1'b0, CSC_ADDR_RATE, 0, 4'hf);
        chk("rate reset", q, 32'h5);
        wb(1'b1, CSC_ADDR_RATE, 32'h7, 4'hf);
        chk("rate bus write", lr, 3'h5);
        pr <= 3'h2; prw <= 1'b1;
        @(posedge clock);
        prw <= 1'b0;
        @(posedge clock);
        chk("rate panel", lr, 3'h2);
        wb(1'b0, 8'h40, 0, 4'hf);
        chk("unmapped read", q, 32'h0);
        wb(1'b1, CSC_ADDR_SEL, 32'h0, 4'h1);
        wb(1'b0, CSC_ADDR_SEL, 0, 4'hf);
        chk("sel byte mask", q, 32'h0000_0300);
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 4; c++)
                apply({5{m[1:0]}}, {5{c[0]}},
                      {c[1], 8'h0, c[1], 1'h0, {3{c[1]}}, 2'h0});
        for (int k = 0; k < 40; k++)
            apply(10'($urandom), 5'($urandom), 16'($urandom));
        stop_test();
    end
endmodule : command_source_combiner_tb
